// ### core/dbgtr_pkg.sv
// Package of the debug trigger and status block.
// Assumes an APB slave with 32-bit data and an 8-bit register view.
package dbgtr_pkg;

	// ==========================================================
	// Register offsets (byte addresses)
	localparam logic [7:0] DBGTR_OFF_CTRL = 8'h00;
	localparam logic [7:0] DBGTR_OFF_TRIG = 8'h04;
	localparam logic [7:0] DBGTR_OFF_STAT = 8'h08;

	// ==========================================================
	// Control register fields
	localparam int DBGTR_CTRL_EN = 7;
	localparam int DBGTR_CTRL_ARM = 6;
	localparam logic [7:0] DBGTR_CTRL_RST = 8'h00;

	// ==========================================================
	// Trigger configuration fields
	localparam int DBGTR_TRIG_SEL = 7;
	localparam int DBGTR_TRIG_BEGIN = 6;
	localparam logic [7:0] DBGTR_TRIG_WMASK = 8'hcf;
	localparam logic [7:0] DBGTR_TRIG_RST = 8'h00;

	// ==========================================================
	// Status register fields
	localparam int DBGTR_STAT_A_HIT = 7;
	localparam int DBGTR_STAT_B_HIT = 6;
	localparam int DBGTR_STAT_RUN = 5;

	// ==========================================================
	// Trace buffer depth and count reset value
	localparam logic [3:0] DBGTR_FIFO_DEPTH = 4'h8;
	localparam logic [3:0] DBGTR_CNT_RST = 4'h0;

	// ==========================================================
	// Trigger mode codes
	localparam logic [3:0] DBGTR_M_A_ONLY = 4'h0;
	localparam logic [3:0] DBGTR_M_A_OR_B = 4'h1;
	localparam logic [3:0] DBGTR_M_A_THEN_B = 4'h2;
	localparam logic [3:0] DBGTR_M_EVT_B = 4'h3;
	localparam logic [3:0] DBGTR_M_A_EVT_B = 4'h4;
	localparam logic [3:0] DBGTR_M_A_AND_D = 4'h5;
	localparam logic [3:0] DBGTR_M_A_NAND_D = 4'h6;
	localparam logic [3:0] DBGTR_M_INSIDE = 4'h7;
	localparam logic [3:0] DBGTR_M_OUTSIDE = 4'h8;

	// Comparator and bus-monitor inputs, all one-cycle valid
	typedef struct packed {
		logic cmp_a;
		logic cmp_b;
		logic exec_a;
		logic exec_b;
		logic data_b;
		logic addr_ge_a;
		logic addr_le_b;
		logic bus_valid;
	} dbgtr_match_s;

	// Run state of the capture sequencer
	typedef enum logic [1:0] {
		DBGTR_IDLE,
		DBGTR_WAIT,
		DBGTR_STORE
	} dbgtr_run_e;

endpackage

// ### core/dbgtr_core.sv
// Trigger selection, run control and status of the bus debug module.
// Assumes comparators and FIFO fill logic outside; pushes arrive as pulses.
//
// Decided for this implementation: the placing of the registers and the APB register port.
module dbgtr_core (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire dbgtr_pkg::dbgtr_match_s match_in,
	input wire logic fifo_push,
	input wire logic chip_secure,
	output logic trigger_pulse,
	output logic capture_store,
	output logic event_store,
	output logic run_start,
	output logic run_active,
	output logic [3:0] valid_word_count
);
	import dbgtr_pkg::*;

	// ==========================================================
	// Register state
	logic [7:0] ctrl_ff;
	logic [7:0] trig_ff;
	logic [7:0] nxt_ctrl;
	logic [7:0] nxt_trig;
	logic [31:0] prdata_ff;
	logic a_flag_ff;
	logic b_flag_ff;
	logic a_seen_ff;
	logic [3:0] cnt_ff;
	dbgtr_run_e run_ff;
	dbgtr_run_e nxt_run;

	// ==========================================================
	// APB decode
	wire setup_ph = psel & ~penable;
	wire access_ph = psel & penable;
	wire hit_ctrl = (paddr == DBGTR_OFF_CTRL);
	wire hit_trig = (paddr == DBGTR_OFF_TRIG);
	wire hit_stat = (paddr == DBGTR_OFF_STAT);
	wire mapped = hit_ctrl | hit_trig | hit_stat;
	wire wr_ctrl = access_ph & pwrite & hit_ctrl;
	wire wr_trig = access_ph & pwrite & hit_trig;

	// Slave always answers in the first access cycle
	assign pready = 1'b1;
	assign pslverr = access_ph & ~mapped;
	assign prdata = prdata_ff;

	// ==========================================================
	// Control fields
	wire en_bit = ctrl_ff[DBGTR_CTRL_EN];
	wire arm_bit = ctrl_ff[DBGTR_CTRL_ARM];
	wire armed = en_bit & arm_bit;
	wire qual_sel = trig_ff[DBGTR_TRIG_SEL];
	wire begin_sel = trig_ff[DBGTR_TRIG_BEGIN];
	wire [3:0] mode = trig_ff[3:0];

	// Control writes on a secured chip store the enable bit as zero
	// secure blocks enable
	wire wr_en = pwdata[DBGTR_CTRL_EN] & ~chip_secure;
	wire wr_arm = pwdata[DBGTR_CTRL_ARM];

	// Arming write starts a new run
	wire start = wr_ctrl & wr_en & wr_arm;
	wire stop_wr = wr_ctrl & ~(wr_en & wr_arm);

	// ==========================================================
	// Comparator qualification
	// tag or force qualification
	wire qa = qual_sel ? match_in.exec_a : match_in.cmp_a;
	wire qb = qual_sel ? match_in.exec_b : match_in.cmp_b;
	wire in_rng = match_in.bus_valid & match_in.addr_ge_a &
		match_in.addr_le_b;
	wire out_rng = match_in.bus_valid &
		~(match_in.addr_ge_a & match_in.addr_le_b);

	// Event-only modes store on B events
	wire evt_mode = (mode == DBGTR_M_EVT_B) | (mode == DBGTR_M_A_EVT_B);
	wire eff_begin = evt_mode | begin_sel;

	// ==========================================================
	// Trigger selector
	logic trig_raw;
	always_comb begin
		case (mode)
			DBGTR_M_A_ONLY: trig_raw = qa;
			DBGTR_M_A_OR_B: trig_raw = qa | qb;
			DBGTR_M_A_THEN_B: trig_raw = a_seen_ff & qb;
			DBGTR_M_EVT_B: trig_raw = qb;
			DBGTR_M_A_EVT_B: trig_raw = a_seen_ff & qb;
			DBGTR_M_A_AND_D: trig_raw = qa & match_in.data_b;
			DBGTR_M_A_NAND_D: trig_raw = qa & ~match_in.data_b;
			DBGTR_M_INSIDE: trig_raw = in_rng;
			DBGTR_M_OUTSIDE: trig_raw = out_rng;
			default: trig_raw = 1'b0;
		endcase
	end

	// Triggers count only inside an armed run
	wire trig_hit = armed & (run_ff != DBGTR_IDLE) & trig_raw;
	assign trigger_pulse = trig_hit & ~evt_mode;
	assign event_store = trig_hit & evt_mode;

	// Buffer full on the eighth push of the run
	wire push_ok = armed & fifo_push & (cnt_ff != DBGTR_FIFO_DEPTH);
	wire fills = push_ok & (cnt_ff == DBGTR_FIFO_DEPTH - 4'h1);

	wire done = armed & ((eff_begin & fills) |
		(~eff_begin & trigger_pulse));

	// ==========================================================
	// Run sequencer
	always_comb begin
		nxt_run = run_ff;
		case (run_ff)
			DBGTR_IDLE: begin
				if (start) begin
					nxt_run = DBGTR_WAIT;
				end
			end
			DBGTR_WAIT: begin
				if (eff_begin & trig_hit) begin
					nxt_run = DBGTR_STORE;
				end
			end
			DBGTR_STORE: nxt_run = DBGTR_STORE;
			default: nxt_run = DBGTR_IDLE;
		endcase
		if (done | stop_wr | ~en_bit) begin
			nxt_run = DBGTR_IDLE;
		end
		if (start) begin
			nxt_run = DBGTR_WAIT;
		end
	end

	assign capture_store = armed & ~evt_mode &
		((run_ff == DBGTR_STORE) | (run_ff == DBGTR_WAIT & ~eff_begin));
	assign run_start = start;

	// ==========================================================
	// Control register next value
	always_comb begin
		nxt_ctrl = ctrl_ff;
		if (wr_ctrl) begin
			nxt_ctrl = pwdata[7:0];
			nxt_ctrl[DBGTR_CTRL_EN] = wr_en;
		end else if (done) begin
			nxt_ctrl[DBGTR_CTRL_ARM] = 1'b0;
		end
	end

	// Trigger configuration next value
	always_comb begin
		nxt_trig = trig_ff;
		if (wr_trig & ~arm_bit) begin
			// bits 4 and 5 held zero
			nxt_trig = pwdata[7:0] & DBGTR_TRIG_WMASK;
		end
	end

	// Register updates
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_ff <= DBGTR_CTRL_RST;
			trig_ff <= DBGTR_TRIG_RST;
			run_ff <= DBGTR_IDLE;
		end else begin
			ctrl_ff <= nxt_ctrl;
			trig_ff <= nxt_trig;
			run_ff <= nxt_run;
		end
	end

	// ==========================================================
	// Match flags and A-seen latch; run start clears them
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			a_flag_ff <= 1'b0;
			b_flag_ff <= 1'b0;
			a_seen_ff <= 1'b0;
		end else if (start) begin
			a_flag_ff <= 1'b0;
			b_flag_ff <= 1'b0;
			a_seen_ff <= 1'b0;
		end else if (armed & (run_ff != DBGTR_IDLE)) begin
			a_flag_ff <= a_flag_ff | qa;
			b_flag_ff <= b_flag_ff | qb;
			a_seen_ff <= a_seen_ff | qa;
		end
	end

	// Valid word count
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_ff <= DBGTR_CNT_RST;
		end else if (start) begin
			cnt_ff <= DBGTR_CNT_RST;
		end else if (push_ok) begin
			cnt_ff <= cnt_ff + 4'h1;
		end
	end

	// ==========================================================
	// Status image and read data
	// arm image while enabled
	wire arm_img = en_bit & arm_bit;
	wire [7:0] stat_img = {a_flag_ff, b_flag_ff, arm_img, 1'b0, cnt_ff};
	wire [7:0] rd_mux = hit_ctrl ? ctrl_ff :
		hit_trig ? trig_ff :
		hit_stat ? stat_img : 8'h00;

	assign run_active = arm_img;
	assign valid_word_count = cnt_ff;

	// status has no write path
	// Read data latched in setup, shown in access
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_ff <= 32'h0000_0000;
		end else if (setup_ph & ~pwrite) begin
			prdata_ff <= {24'h00_0000, rd_mux};
		end
	end

	// ==========================================================
	// Checks
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	a_trig_write_lock: assert property (
		wr_trig & arm_bit |=> $stable(trig_ff))
		else $error("trigger config changed while armed");

	a_trig_zero_bits: assert property (
		trig_ff[5:4] == 2'b00)
		else $error("trigger config bits 5:4 not zero");

	a_trig_write_ok: assert property (
		wr_trig & ~arm_bit |=>
		trig_ff == ($past(pwdata[7:0]) & DBGTR_TRIG_WMASK))
		else $error("trigger config write lost");

	a_reserved_mode: assert property (
		mode > DBGTR_M_OUTSIDE |-> ~trig_hit)
		else $error("reserved mode triggered");

	a_flag_clear_run: assert property (
		start |=> ~a_flag_ff & ~b_flag_ff & cnt_ff == 4'h0)
		else $error("flags or count not cleared at start");

	a_flag_a_set: assert property (
		armed & run_ff != DBGTR_IDLE & qa & ~start |=> a_flag_ff)
		else $error("A flag missed a match");

	a_flag_b_set: assert property (
		armed & run_ff != DBGTR_IDLE & qb & ~start |=> b_flag_ff)
		else $error("B flag missed a match");

	a_end_trace_done: assert property (
		armed & ~eff_begin & trigger_pulse & ~wr_ctrl |=>
		~arm_bit & run_ff == DBGTR_IDLE)
		else $error("end trace run did not finish");

	a_manual_stop: assert property (
		wr_ctrl & ~wr_arm |=> ~run_active & run_ff == DBGTR_IDLE)
		else $error("manual stop ignored");

	a_secure_enable: assert property (
		wr_ctrl & chip_secure |=> ~en_bit)
		else $error("enable set while secured");

	a_count_limit: assert property (
		cnt_ff <= DBGTR_FIFO_DEPTH)
		else $error("word count above eight");

	a_count_hold: assert property (
		~start |=> cnt_ff >= $past(cnt_ff))
		else $error("word count decreased");

	a_event_begin: assert property (
		evt_mode & armed & fills & ~wr_ctrl |=> ~run_active)
		else $error("event run did not end on full buffer");

	a_run_start_arm: assert property (
		run_start |=> run_active)
		else $error("arming write did not raise run flag");

	a_begin_no_store: assert property (
		armed & eff_begin & run_ff == DBGTR_WAIT |-> ~capture_store)
		else $error("begin trace stored before its trigger");

	a_end_trace_store: assert property (
		armed & ~eff_begin & run_ff != DBGTR_IDLE |-> capture_store)
		else $error("end trace run not storing");

endmodule

// ### testbench/dbgtr_bus_model.sv
// Model of the watched CPU bus and the trace buffer fill logic.
// Assumes the bench supplies bus events, one cycle each.
module dbgtr_bus_model (
	input wire logic pclk,
	input wire logic presetn,
	input wire dbgtr_pkg::dbgtr_match_s stim,
	input wire logic capture_store,
	input wire logic event_store,
	output dbgtr_pkg::dbgtr_match_s match_in,
	output logic fifo_push
);
	timeunit 1ns;
	timeprecision 1ns;
	import dbgtr_pkg::*;

	// Bus events pass to the comparator outputs unchanged
	assign match_in = stim;

	// One stored word per qualified bus cycle or event
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			fifo_push <= 1'b0;
		else
			fifo_push <= (capture_store & match_in.bus_valid) | event_store;
	end
endmodule

// ### testbench/dbgtr_core_tb.sv
// Self-checking bench of the debug trigger and status block.
// Assumes a zero-wait APB slave and the bus model beside it.
module dbgtr_core_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import dbgtr_pkg::*;

	// ==========================================================
	// Signals
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic chip_secure = 1'b0;
	logic [31:0] prdata;
	logic pready, pslverr, fifo_push, cap, evt, fire, act;
	logic [3:0] vwc;
	dbgtr_match_s stim = '0;
	dbgtr_match_s match_in;
	integer seed = 32'h640f;
	integer fail_count = 0;
	integer n_compared = 0;
	integer cyc = 0;
	logic [16:0] exp_q[$];
	logic [16:0] e;
	logic [7:0] d, n;

	always #50 pclk = ~pclk;

	dbgtr_core dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.match_in(match_in), .fifo_push(fifo_push),
		.chip_secure(chip_secure), .trigger_pulse(), .capture_store(cap),
		.event_store(evt), .run_start(), .run_active(act),
		.valid_word_count(vwc));

	dbgtr_bus_model bus (.pclk(pclk), .presetn(presetn), .stim(stim),
		.capture_store(cap), .event_store(evt), .match_in(match_in),
		.fifo_push(fifo_push));

	// ==========================================================
	// Tasks
	task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
		n_compared++;
		if (seen !== exp) begin
			fail_count++;
			$display("[FAIL] %0t read got %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic complete_run();
		$display("compared %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task automatic apb(input logic w, input logic [7:0] a,
		input logic [7:0] v);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, v};
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] x,
		input logic [7:0] m, input logic err);
		exp_q.push_back({err, m, x & m});
		apb(1'b0, a, 8'h00);
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		apb(1'b1, a, v);
	endtask

	task automatic pulse(input dbgtr_match_s v);
		stim <= v;
		@(posedge pclk);
		stim <= '0;
		@(posedge pclk);
	endtask

	task automatic flow(input logic [7:0] k);
		stim <= dbgtr_match_s'(8'h01);
		repeat (k) @(posedge pclk);
		stim <= '0;
		@(posedge pclk);
	endtask

	// Read checker and hang limit
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 3000) begin
			fail_count++;
			complete_run();
		end
		if (psel && penable && pready && !pwrite && exp_q.size() > 0) begin
			e = exp_q.pop_front();
			chk({pslverr, prdata[7:0] & e[15:8]}, {e[16], e[7:0]});
			// Run flag and word count pins against the status image
			if (paddr == DBGTR_OFF_STAT) begin
				chk({1'b0, {2'b00, act, 1'b0, vwc} & e[15:8]},
					{1'b0, e[7:0] & 8'h2f});
			end
		end
	end

	// ==========================================================
	// Main sequence
	initial begin
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		rd(DBGTR_OFF_CTRL, 8'h00, 8'hff, 1'b0);
		rd(DBGTR_OFF_TRIG, 8'h00, 8'hff, 1'b0);
		rd(DBGTR_OFF_STAT, 8'h00, 8'hff, 1'b0);
		rd(8'h0c, 8'h00, 8'hff, 1'b1);
		d = $random(seed);
		wr(DBGTR_OFF_TRIG, d);
		rd(DBGTR_OFF_TRIG, d & 8'hcf, 8'hff, 1'b0);
		wr(DBGTR_OFF_STAT, 8'hff);
		rd(DBGTR_OFF_STAT, 8'h00, 8'hff, 1'b0);
		chip_secure <= 1'b1;
		wr(DBGTR_OFF_CTRL, 8'hc0);
		rd(DBGTR_OFF_CTRL, 8'h00, 8'h80, 1'b0);
		rd(DBGTR_OFF_STAT, 8'h00, 8'hff, 1'b0);
		chip_secure <= 1'b0;
		// Refused enable left the arm bit stored; clear it first
		wr(DBGTR_OFF_CTRL, 8'h00);
		wr(DBGTR_OFF_TRIG, 8'h80);
		wr(DBGTR_OFF_CTRL, 8'hc0);
		wr(DBGTR_OFF_TRIG, 8'h41);
		rd(DBGTR_OFF_TRIG, 8'h80, 8'hff, 1'b0);
		pulse('{1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1});
		rd(DBGTR_OFF_STAT, 8'h20, 8'h20, 1'b0);
		pulse('{1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1});
		rd(DBGTR_OFF_STAT, 8'h80, 8'ha0, 1'b0);
		wr(DBGTR_OFF_CTRL, 8'h00);
		// Every mode code with the begin bit clear (end trace, but event-only for codes 3 and 4), fired or still armed
		for (int m = 0; m < 16; m++) begin
			d = $random(seed);
			fire = (m < 3) || (m == 5 && d[0]) || (m == 6 && !d[0]) ||
				m == 7 || m == 8;
			wr(DBGTR_OFF_TRIG, {4'h0, m[3:0]});
			wr(DBGTR_OFF_CTRL, 8'hc0);
			pulse('{1'b1, 1'b0, 1'b1, 1'b0, d[0], 1'b1, 1'b1, 1'b1});
			pulse('{1'b0, 1'b1, 1'b0, 1'b1, d[0], 1'b1, 1'b0, 1'b1});
			rd(DBGTR_OFF_STAT, {2'b00, !fire, 5'h00}, 8'h20,
				1'b0);
			wr(DBGTR_OFF_CTRL, 8'h00);
		end
		// Begin trace until the buffer is full
		wr(DBGTR_OFF_TRIG, 8'h40);
		wr(DBGTR_OFF_CTRL, 8'hc0);
		rd(DBGTR_OFF_STAT, 8'h20, 8'hff, 1'b0);
		pulse('{1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0});
		flow(8'd12);
		rd(DBGTR_OFF_STAT, 8'h88, 8'hff, 1'b0);
		rd(DBGTR_OFF_STAT, 8'h88, 8'hff, 1'b0);
		// Begin trace stopped by hand after a few words
		// host side keeps its own word count
		n = 8'(1 + ($unsigned($random(seed)) % 7));
		wr(DBGTR_OFF_CTRL, 8'hc0);
		pulse('{1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0});
		flow(n);
		wr(DBGTR_OFF_CTRL, 8'h80);
		rd(DBGTR_OFF_STAT, 8'h80 | n, 8'hff, 1'b0);
		wr(DBGTR_OFF_CTRL, 8'hc0);
		wr(DBGTR_OFF_CTRL, 8'h40);
		rd(DBGTR_OFF_STAT, 8'h00, 8'h20, 1'b0);
		repeat (2) @(posedge pclk);
		complete_run();
	end
endmodule
